// ===== ipa_pkg.sv
// Shared constants, layouts and types of the indirect pointer addressing unit.
package ipa_pkg;

  // Data path widths and default pair count.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PAIRS_DEFAULT = 3;

  // Operand block of pointer pair n starts at PAIR0_BASE - n * PAIR_STRIDE.
  localparam logic [11:0] PAIR0_BASE = 12'hFEB;
  localparam logic [11:0] PAIR_STRIDE = 12'h008;
  localparam logic [11:0] OPND_LAST = 12'h004;
  localparam logic [11:0] PTR_LOW_GAP = 12'h002;
  localparam logic [11:0] PTR_HIGH_GAP = 12'h001;

  // Offsets of the virtual operands inside an operand block.
  localparam logic [2:0] OFS_ACC_OFFSET = 3'h0;
  localparam logic [2:0] OFS_PRE_INC = 3'h1;
  localparam logic [2:0] OFS_POST_DEC = 3'h2;
  localparam logic [2:0] OFS_POST_INC = 3'h3;
  localparam logic [2:0] OFS_INDIRECT = 3'h4;

  // Index of indirect_operand_one; its bus byte address is four times this.
  localparam logic [11:0] INDIRECT_OPERAND_ONE_IDX = 12'hFE7;

  // Bus map: data location a sits at byte address 4 * a.
  localparam logic [15:0] CTRL_ADDR = 16'h0000;
  localparam logic [15:0] STATUS_ADDR = 16'h0004;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int STATUS_BUSY_BIT = 16;
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Access request from the execution logic, and request to data memory.
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [7:0] wdata;
  } ipa_req_t;

  // Result of decoding one data address.
  typedef struct packed {
    logic virt;
    logic ptr;
    logic hi;
    logic [1:0] pair;
    logic [2:0] ofs;
  } ipa_dec_t;

  typedef enum logic {IPA_IDLE, IPA_MEM} ipa_state_t;

endpackage

// ===== ipa_indirect.sv
// Indirect pointer addressing unit with its AHB-Lite register slave.
`timescale 1ns/1ps

module ipa_indirect #(
  parameter int NUM_PAIRS = ipa_pkg::PAIRS_DEFAULT
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Execution logic side.
  input wire ipa_pkg::ipa_req_t cpu_req,
  input wire logic [7:0] cpu_accum,
  output logic cpu_ready,
  output logic cpu_done,
  output logic [7:0] cpu_rdata,
  // Data memory side.
  output ipa_pkg::ipa_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  import ipa_pkg::*;

  // Data address map seen by the execution logic.
  // Each pointer pair owns a block of five virtual operands.
  // The block of pair n starts at PAIR0_BASE minus n times PAIR_STRIDE.
  // Inside a block the operands sit in this order:
  // the accumulator offset operand, the pre-increment operand,
  // the post-decrement operand, the post-increment operand,
  // and last the plain indirect operand.
  // The two pointer bytes sit just below the block of their pair.
  // The low byte is two below the block start, the high byte one below.
  // The virtual operands hold no storage at all.
  // Every other address is passed through to data memory unchanged.
  // A pair holds twelve bits; the high byte keeps only four of them.
  // The upper four bits of a high byte always read back as zero.
  // Up to four pairs fit the two-bit pair field of the decode result.

  logic [11:0] ptr [NUM_PAIRS];
  logic ctrl_enable;
  logic [11:0] last_ea;
  ipa_state_t state;
  logic ahb_act;
  logic ahb_wr;
  logic [31:0] ahb_addr;
  logic ahb_in_range;
  ipa_dec_t ahb_dec;
  logic ahb_ptr_wr;
  ipa_dec_t req_dec;
  ipa_dec_t tgt_dec;
  logic [11:0] cur_ptr;
  logic [11:0] ea;
  logic [11:0] next_ptr;
  logic [11:0] tgt_addr;
  logic take;
  logic tgt_void;
  logic need_mem;
  logic cpu_ptr_wr;
  logic upd;
  logic [7:0] tgt_ptr_byte;

  // The same decode serves three places: the bus data phase, the
  // incoming request and the address that a virtual operand reaches.
  // Using one function keeps the three views of the map identical.
  // The loop walks every pair, so a wider NUM_PAIRS needs no new code.
  // A hit sets either the virtual flag or the pointer flag, never both,
  // because the pointer bytes lie outside every operand block.
  // An address that hits nothing decodes to all zeros.
  // Classifies a data address as virtual operand, pointer byte or other.
  function automatic ipa_dec_t ipa_decode(input logic [11:0] a);
    ipa_dec_t d;
    logic [11:0] base;
    d = '0;
    base = '0;
    for (int n = 0; n < NUM_PAIRS; n++) begin
      base = PAIR0_BASE - 12'(n) * PAIR_STRIDE;
      if (a >= base && a <= base + OPND_LAST) begin
        d.virt = 1'b1;
        d.pair = 2'(n);
        d.ofs = 3'(a - base);
      end
      if (a == base - PTR_LOW_GAP || a == base - PTR_HIGH_GAP) begin
        d.ptr = 1'b1;
        d.pair = 2'(n);
        d.hi = (a == base - PTR_HIGH_GAP);
      end
    end
    return d;
  endfunction

  // The slave never stalls and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // The bus runs with zero wait states: the address phase is captured
  // at the edge where hready is high, and the data phase follows in the
  // very next cycle.  Writes land at the end of the data phase, so a
  // read issued right behind a write already sees the new value.
  // Transfers of any size other than a word are dropped silently.
  // Address phase capture; only word transfers are taken.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_act <= 1'b0;
      ahb_wr <= 1'b0;
      ahb_addr <= '0;
    end else if (hready) begin
      ahb_act <= hsel && htrans[1] && hsize == HSIZE_WORD;
      ahb_wr <= hwrite;
      ahb_addr <= haddr;
    end
  end

  // Data phase decode of the captured address.
  assign ahb_in_range = ahb_addr[31:14] == '0 && ahb_addr[1:0] == 2'h0;
  assign ahb_dec = ipa_decode(ahb_addr[13:2]);
  assign ahb_ptr_wr = ahb_act && ahb_wr && ahb_in_range && ahb_dec.ptr;

  // Read data is driven only in the data phase of a word read, so the
  // bus shows zero at every other time.
  // Virtual operand addresses read zero here, since they hold nothing.
  // Read data: control, status, pointer bytes; anything else reads zero.
  always_comb begin
    hrdata = '0;
    if (ahb_act && !ahb_wr && ahb_in_range) begin
      if (ahb_addr[15:0] == CTRL_ADDR) begin
        hrdata[CTRL_ENABLE_BIT] = ctrl_enable;
      end else if (ahb_addr[15:0] == STATUS_ADDR) begin
        hrdata[11:0] = last_ea;
        hrdata[STATUS_BUSY_BIT] = state == IPA_MEM;
      end else if (ahb_dec.ptr) begin
        hrdata[7:0] = ahb_dec.hi ? {4'h0, ptr[ahb_dec.pair][11:8]}
                                 : ptr[ahb_dec.pair][7:0];
      end
    end
  end

  // Control register: the enable gates acceptance of new accesses.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_enable <= CTRL_ENABLE_RESET;
    end else if (ahb_act && ahb_wr && ahb_in_range &&
                 ahb_addr[15:0] == CTRL_ADDR) begin
      ctrl_enable <= hwdata[CTRL_ENABLE_BIT];
    end
  end

  // Request decode and effective address generation.
  assign cpu_ready = ctrl_enable && state == IPA_IDLE;
  assign take = cpu_req.valid && cpu_ready;
  assign req_dec = ipa_decode(cpu_req.addr);
  assign cur_ptr = ptr[req_dec.pair];

  // The effective address and the next pointer value are worked out in
  // the same cycle as the request, so the update commits at the take.
  // The sign of the accumulator is extended over the four upper bits,
  // which lets a negative offset reach below the pointer.
  // All sums wrap at twelve bits, so an increment past FFF gives 000.
  // Carry from the low byte into the high byte comes free with the
  // single twelve-bit adder.
  // Effective address and next pointer value for each operand kind.
  always_comb begin
    ea = cur_ptr;
    next_ptr = cur_ptr;
    case (req_dec.ofs)
      OFS_ACC_OFFSET: begin
        ea = cur_ptr + {{4{cpu_accum[7]}}, cpu_accum};
      end
      OFS_PRE_INC: begin
        ea = cur_ptr + 12'h001;
        next_ptr = cur_ptr + 12'h001;
      end
      OFS_POST_DEC: begin
        next_ptr = cur_ptr - 12'h001;
      end
      OFS_POST_INC: begin
        next_ptr = cur_ptr + 12'h001;
      end
      OFS_INDIRECT: begin
        ea = cur_ptr;
      end
      default: begin
        ea = cur_ptr;
      end
    endcase
  end

  // Virtual operands redirect through their pair; others are direct.
  assign tgt_addr = req_dec.virt ? ea : cpu_req.addr;
  assign tgt_dec = ipa_decode(tgt_addr);
  assign tgt_void = req_dec.virt && tgt_dec.virt;
  assign need_mem = !tgt_dec.virt && !tgt_dec.ptr;
  assign cpu_ptr_wr = take && cpu_req.write && tgt_dec.ptr;
  assign upd = take && req_dec.virt && !(cpu_req.write && tgt_dec.ptr);
  assign tgt_ptr_byte = tgt_dec.hi ? {4'h0, ptr[tgt_dec.pair][11:8]}
                                   : ptr[tgt_dec.pair][7:0];

  // Software that rewrites a pointer byte moves every later access made
  // through that pair; nothing here guards against that.
  // When a bus write and a data write hit the same pair in one cycle,
  // the bus write wins and the data write is lost.
  // A write that a virtual operand sends to a pointer byte stores the
  // byte and skips the automatic update of the operand's own pair.
  // Pointer pairs: bus writes first, then data writes, then auto updates.
  // Only the pointer changes here; no status flag is produced at all.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int n = 0; n < NUM_PAIRS; n++) begin
        ptr[n] <= PTR_RESET;
      end
    end else begin
      for (int n = 0; n < NUM_PAIRS; n++) begin
        if (ahb_ptr_wr && ahb_dec.pair == 2'(n)) begin
          if (ahb_dec.hi) begin
            ptr[n][11:8] <= hwdata[3:0];
          end else begin
            ptr[n][7:0] <= hwdata[7:0];
          end
        end else if (cpu_ptr_wr && tgt_dec.pair == 2'(n)) begin
          if (tgt_dec.hi) begin
            ptr[n][11:8] <= cpu_req.wdata[3:0];
          end else begin
            ptr[n][7:0] <= cpu_req.wdata;
          end
        end else if (upd && req_dec.pair == 2'(n)) begin
          ptr[n] <= next_ptr;
        end
      end
    end
  end

  // Only accesses that reach data memory leave the idle state.
  // While waiting, cpu_ready is low, so no second request can be taken
  // and the held memory request cannot be overwritten.
  // Access sequencing: wait in IPA_MEM until data memory acknowledges.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= IPA_IDLE;
    end else begin
      case (state)
        IPA_IDLE: begin
          if (take && need_mem) begin
            state <= IPA_MEM;
          end
        end
        IPA_MEM: begin
          if (mem_ack) begin
            state <= IPA_IDLE;
          end
        end
        default: begin
          state <= IPA_IDLE;
        end
      endcase
    end
  end

  // Memory request is held until acknowledged.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req <= '0;
    end else if (take && need_mem) begin
      mem_req.valid <= 1'b1;
      mem_req.write <= cpu_req.write;
      mem_req.addr <= tgt_addr;
      mem_req.wdata <= cpu_req.wdata;
    end else if (mem_ack) begin
      mem_req.valid <= 1'b0;
    end
  end

  // Internal targets answer one cycle after the take; memory targets
  // answer one cycle after the acknowledge.  Writes and void reads
  // return zero so that stale data never leaks to the requester.
  // Answer to the execution logic: one-cycle done pulse with read data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_done <= 1'b0;
      cpu_rdata <= '0;
    end else if (take && !need_mem) begin
      cpu_done <= 1'b1;
      if (tgt_void || cpu_req.write) begin
        cpu_rdata <= '0;
      end else begin
        cpu_rdata <= tgt_ptr_byte;
      end
    end else if (state == IPA_MEM && mem_ack) begin
      cpu_done <= 1'b1;
      cpu_rdata <= mem_req.write ? 8'h00 : mem_rdata;
    end else begin
      cpu_done <= 1'b0;
    end
  end

  // Status: address reached by the last accepted access.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_ea <= '0;
    end else if (take) begin
      last_ea <= tgt_addr;
    end
  end

endmodule

// ===== ipa_indirect_asserts.sv
// Port property checker of the indirect pointer addressing unit.
`timescale 1ns/1ps
module ipa_indirect_asserts #(
  parameter int NUM_PAIRS = 3
) (
  // Clock, reset and bus.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Execution and memory sides.
  input wire ipa_pkg::ipa_req_t cpu_req,
  input wire logic cpu_ready,
  input wire logic cpu_done,
  input wire logic [7:0] cpu_rdata,
  input wire ipa_pkg::ipa_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  import ipa_pkg::*;
  logic rd_ph;
  logic [31:0] rd_a;
  // Marks the data phase of an accepted word read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph <= 1'b0;
      rd_a <= 32'h0;
    end else begin
      rd_ph <= hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
      rd_a <= haddr;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take;
    cpu_req.valid && cpu_ready;
  endsequence
  sequence s_mem_done;
    mem_req.valid && mem_ack && !mem_req.write;
  endsequence
  a_resp_okay:
    assert property (hreadyout && !hresp) else $error("bus stalled");
  a_mem_launch:
    assert property (s_take ##0 (cpu_req.addr[11:8] != 4'hF) |=>
      mem_req.valid && mem_req.addr == $past(cpu_req.addr))
      else $error("memory access not launched");
  a_mem_hold:
    assert property (mem_req.valid && !mem_ack |=> $stable(mem_req))
      else $error("memory request moved");
  a_done_ack:
    assert property (s_mem_done |=> cpu_done && !mem_req.valid &&
      cpu_rdata == $past(mem_rdata)) else $error("bad memory answer");
  a_ready_wait:
    assert property (mem_req.valid |-> !cpu_ready)
      else $error("ready while waiting");
  a_ptr_done:
    assert property (s_take ##0 (cpu_req.addr == 12'hFE9) |=>
      cpu_done && !mem_req.valid) else $error("pointer not internal");
  a_hrdata_idle:
    assert property (!rd_ph |-> hrdata == 32'h0)
      else $error("read data outside phase");
  a_hi_clear:
    assert property (rd_ph && rd_a == 32'h3FA8 |-> hrdata[31:4] == 28'h0)
      else $error("high pointer byte too wide");
endmodule

bind ipa_indirect ipa_indirect_asserts #(.NUM_PAIRS(NUM_PAIRS)) u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
  .hreadyout, .hresp, .hrdata, .cpu_req, .cpu_ready, .cpu_done,
  .cpu_rdata, .mem_req, .mem_ack, .mem_rdata);

// ===== ipa_mem_model.sv
// Behavioural data memory answering the unit's memory port.
`timescale 1ns/1ps
module ipa_mem_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Memory port.
  input wire ipa_pkg::ipa_req_t mem_req,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  // Control and observation.
  input wire logic slow,
  output logic [11:0] last_addr,
  output int n_acc
);
  import ipa_pkg::*;
  int wt;
  // Acks after zero or three waits; data churns when not acked.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      last_addr <= 12'h000;
      n_acc <= 0;
      wt <= 0;
    end else if (mem_req.valid && !mem_ack && wt >= (slow ? 3 : 0)) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_req.addr[7:0] ^ 8'hA5;
      last_addr <= mem_req.addr;
      n_acc <= n_acc + 1;
      wt <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wt <= mem_req.valid ? wt + 1 : 0;
    end
  end
endmodule

// ===== ipa_indirect_tb_top.sv
// Self-checking testbench of the indirect pointer addressing unit.
`timescale 1ns/1ps
module ipa_indirect_tb_top;
  import ipa_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic slow = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata, b;
  logic hreadyout, hresp, cpu_ready, cpu_done, mem_ack;
  logic [7:0] cpu_accum = 0;
  logic [7:0] cpu_rdata, mem_rdata, r;
  ipa_req_t cpu_req = '0;
  ipa_req_t mem_req;
  logic [11:0] last_addr;
  int n_acc, na;
  int n_errors = 0;
  int total_checks = 0;
  // Clock of 4 ns period.
  always #2 hclk = ~hclk;
  ipa_indirect u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .cpu_req, .cpu_accum, .cpu_ready, .cpu_done, .cpu_rdata, .mem_req,
    .mem_ack, .mem_rdata);
  ipa_mem_model u_mem (.hclk, .hresetn, .mem_req, .mem_ack, .mem_rdata,
    .slow, .last_addr, .n_acc);
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, a, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task cpu(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge hclk);
    cpu_req <= '{1'b1, w, a, d};
    do @(posedge hclk); while (cpu_ready !== 1'b1);
    cpu_req <= '0;
    do @(posedge hclk); while (cpu_done !== 1'b1);
    q = cpu_rdata;
  endtask
  task ptr(input logic [11:0] v);
    ahb(1, 12'hFE9, v[7:0], b);
    ahb(1, 12'hFEA, {4'h0, v[11:8]}, b);
  endtask
  task t_walk;
    ahb(0, 12'h000, 0, b);
    chk("ctrl", 1, b);
    ahb(0, 12'h002, 0, b);
    chk("unmapped", 0, b);
    ptr(12'h2FF);
    ahb(1, 12'hFEA, 8'hF2, b);
    ahb(0, 12'hFEA, 0, b);
    chk("hi", 2, b);
    slow <= 1;
    cpu(0, 12'hFEE, 0, r);
    chk("inc", 12'h2FF, last_addr);
    chk("data", 8'h5A, r);
    cpu(0, 12'hFE9, 0, r);
    chk("inc_lo", 0, r);
    cpu(0, 12'hFEA, 0, r);
    chk("inc_hi", 3, r);
    slow <= 0;
    cpu(0, 12'hFED, 0, r);
    chk("dec", 12'h300, last_addr);
    ahb(0, 12'hFEA, 0, b);
    chk("dec_hi", 2, b);
    cpu(1, 12'hFEC, 8'h77, r);
    chk("pre", 12'h300, last_addr);
  endtask
  task t_offset;
    cpu_accum <= 8'h80;
    cpu(0, 12'hFEB, 0, r);
    chk("neg", 12'h280, last_addr);
    cpu_accum <= 8'h7F;
    cpu(0, 12'hFEB, 0, r);
    chk("pos", 12'h37F, last_addr);
    cpu(0, 12'hFEF, 0, r);
    chk("plain", 12'h300, last_addr);
    ahb(0, 12'hFE9, 0, b);
    chk("kept", 0, b);
  endtask
  task t_special;
    ptr(12'hFE7);
    na = n_acc;
    cpu(0, 12'hFEF, 0, r);
    chk("void_rd", 0, r);
    cpu(1, 12'hFEF, 8'h55, r);
    chk("void_wr", na, n_acc);
    cpu(0, 12'hFE7, 0, r);
    chk("redir", 0, last_addr);
    ptr(12'hFE9);
    cpu(1, 12'hFEE, 8'h44, r);
    ahb(0, 12'hFE9, 0, b);
    chk("self", 8'h44, b);
    ptr(12'hFD9);
    cpu(1, 12'hFEF, 8'h5A, r);
    cpu(0, 12'hFD9, 0, r);
    chk("sfr", 8'h5A, r);
  endtask
  task t_direct;
    cpu(0, 12'h123, 0, r);
    chk("direct_addr", 12'h123, last_addr);
    chk("direct_data", 8'h86, r);
    ahb(0, 12'h001, 0, b);
    chk("status", 32'h00000123, b);
    ahb(1, 12'h000, 8'h00, b);
    @(posedge hclk);
    chk("disabled", 1'b0, cpu_ready);
    ahb(1, 12'h000, 8'h01, b);
    ahb(0, 12'h000, 0, b);
    chk("enabled", 1, b);
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence after a three cycle reset.
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    t_walk;
    t_offset;
    t_special;
    t_direct;
    final_report;
  end
  // Watchdog against a hung handshake.
  initial begin
    #20000;
    n_errors++;
    final_report;
  end
endmodule
